// File: testbench/wake_pin_source.sv
// External wakeup pin driver model
`timescale 1ns/1ps
module wake_pin_source (
	input wire clk_i,
	input wire [3:0] want_i,
	output reg [3:0] pin_o = 4'hf
);
	reg [2:0] age_r = 3'h0;
	always @(posedge clk_i) begin
		if (age_r < 3'h5) age_r <= age_r + 3'h1;
		else if (want_i != pin_o) begin
			pin_o <= want_i;
			age_r <= 3'h0;
		end
	end
endmodule

// File: testbench/wake_status_check_assertions.sv
// Port timing checker of the wakeup status block
`timescale 1ns/1ps
module wake_status_check (
	// Clock, reset and event inputs
	input wire core_clk_i, reset_n_i, level_one_reset_i, sleeping_i,
	input wire line_supply_low_i, line_supply_high_i,
	input wire power_down_int_enable_i, sfr_wr_i,
	input wire [7:0] sfr_addr_i, sfr_wdata_i,
	// Design outputs
	input wire [7:0] sfr_rdata_o,
	input wire wake_o, power_down_int_o
);
	// Internal reset lifts two edges after release, so wait three
	reg [1:0] up_r;
	wire rdy = &up_r;
	always @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i) up_r <= 2'h0;
		else if (!rdy) up_r <= up_r + 2'h1;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_wr;
		rdy && sfr_wr_i && sfr_addr_i == 8'hc7 ##1 sfr_addr_i == 8'hc7;
	endsequence
	sequence s_l1(a);
		rdy && level_one_reset_i ##1 !level_one_reset_i && sfr_addr_i == a;
	endsequence
	a_edge_sel_read: assert property (s_wr |=>
		sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("edge read bad");
	a_l1_sets_flag: assert property (s_l1(8'ha1) |=>
		sfr_rdata_o[5]) else $error("level one flag not set");
	a_l1_clears_src: assert property (s_l1(8'haf) |=>
		sfr_rdata_o == 8'h00) else $error("flags not cleared");
	a_unmapped_zero: assert property (rdy && sfr_addr_i != 8'ha1 &&
		sfr_addr_i != 8'haf && sfr_addr_i != 8'hc7 |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_loss_int: assert property (rdy && $past(line_supply_low_i) &&
		power_down_int_enable_i |-> power_down_int_o) else $error("no int");
	a_present_no_int: assert property (rdy &&
		$past(line_supply_high_i) |-> !power_down_int_o) else $error("int");
	a_wake_asleep: assert property (wake_o |->
		sleeping_i) else $error("wake while awake");
	a_wake_once: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
endmodule
bind wakeup_source_status wake_status_check i_wake_status_check (
	.core_clk_i, .reset_n_i, .level_one_reset_i, .sleeping_i,
	.line_supply_low_i, .line_supply_high_i, .power_down_int_enable_i,
	.sfr_wr_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .wake_o,
	.power_down_int_o);

// File: testbench/wakeup_source_status_test.sv
// Self-checking bench of the wakeup status block
`timescale 1ns/1ps
module wakeup_source_status_test;
	reg core_clk = 1'b0, reset_n = 1'b0, lvl = 1'b0, slp = 1'b0, v;
	reg tmr = 1'b0, pulse = 1'b0, pulse_en = 1'b0, low = 1'b0, high = 1'b0;
	reg pz = 1'b1, pdi_en = 1'b1, wr = 1'b0, rcv = 1'b0;
	reg [7:0] addr = 8'h00, wdata = 8'h00;
	reg [3:0] want = 4'hf;
	reg [31:0] seed = 32'h644198fa;
	wire [3:0] pin;
	wire [7:0] rdata;
	wire wake, pdi;
	integer n_errors = 0, tests_run = 0, k, t;
	wake_pin_source i_wake_pin_source (.clk_i(core_clk), .want_i(want),
		.pin_o(pin));
	wakeup_source_status #(.HOLD(2)) i_wakeup_source_status (
		.core_clk_i(core_clk), .reset_n_i(reset_n), .sleeping_i(slp),
		.level_one_reset_i(lvl), .timer_wake_i(tmr),
		.energy_pulse_output_i(pulse), .pulse_wake_enable_i(pulse_en),
		.supply_recover_i(rcv), .line_supply_low_i(low),
		.line_supply_high_i(high), .port_zero_wake_enable_i(pz),
		.power_down_int_enable_i(pdi_en), .wake_pin_one_i(pin[0]),
		.wake_pin_two_i(pin[1]), .wake_pin_three_i(pin[2]),
		.wake_pin_four_i(pin[3]), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .wake_o(wake),
		.power_down_int_o(pdi));
	// Free-running 100 MHz clock
	initial forever #5 core_clk = ~core_clk;
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// Expected flag bit of a pin; pin two owns none
	function [7:0] flag(input integer p);
		flag = p == 0 ? 8'h01 : p == 2 ? 8'h02 : p == 3 ? 8'h04 : 8'h00;
	endfunction
	function [7:0] esel(input integer p, input integer c);
		esel = {6'h00, c[1:0]} << (p == 0 ? 2 : p == 1 ? 0 : 2 * p);
	endfunction
	task chk(input [7:0] e, input [7:0] g, input [7:0] m, input [63:0] nm);
		tests_run = tests_run + 1;
		if ((g & m) !== (e & m)) begin
			n_errors = n_errors + 1;
			$display("mismatch %0s exp %h got %h addr %h", nm, e & m,
				g & m, addr);
		end
	endtask
	// Read data lands one cycle after the address
	task rd(input [7:0] a, input [7:0] e, input [7:0] m);
		addr <= a;
		repeat (2) @(posedge core_clk);
		#1 chk(e, rdata, m, "rdata");
		@(posedge core_clk);
	endtask
	task wrt(input [7:0] a, input [7:0] d);
		addr <= a;
		wr <= 1'b1;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	// Bounded watch for a wake pulse, looked at 1 ns after each edge
	task ww(input e);
		v = 1'b0;
		for (t = 0; t < 20; t = t + 1) begin
			#1;
			if (wake === 1'b1) v = 1'b1;
			@(posedge core_clk);
		end
		chk({7'h00, e}, {7'h00, v}, 8'h01, "wake");
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(8'ha1, 8'h20, 8'hff);
		rd(8'haf, 8'h00, 8'hff);
		rd(8'h55, 8'h00, 8'hff);
		seed = xs(seed);
		// Status register ignores writes; edge select keeps them
		wrt(8'ha1, seed[7:0]);
		rd(8'ha1, 8'h20, 8'hff);
		wrt(8'hc7, seed[15:8]);
		rd(8'hc7, seed[15:8], 8'hff);
		// Random edge select patterns read back unchanged
		for (k = 0; k < 8; k = k + 1) begin
			seed = xs(seed);
			wrt(8'hc7, seed[7:0]);
			rd(8'hc7, seed[7:0], 8'hff);
		end
		// Every edge code, one per pin
		for (k = 0; k < 4; k = k + 1) begin
			wrt(8'hc7, esel(k, k));
			want[k] <= 1'b0;
			slp <= k != 1;
			ww(k != 1);
			slp <= 1'b1;
			want[k] <= 1'b1;
			ww(k == 1 || k == 2);
			slp <= 1'b0;
			rd(8'ha1, 8'h08, 8'h28);
			rd(8'haf, flag(k), 8'hff);
		end
		// Pin four refused without port-zero enable
		pz <= 1'b0;
		slp <= 1'b1;
		want[3] <= 1'b0;
		ww(1'b0);
		slp <= 1'b0;
		want[3] <= 1'b1;
		ww(1'b0);
		// Timer wake with a disabled pulse, then pulse wake; one cycle each
		for (k = 0; k < 2; k = k + 1) begin
			slp <= 1'b1;
			pulse_en <= k == 1;
			pulse <= 1'b1;
			tmr <= k == 0;
			#1 chk(8'h01, {7'h00, wake}, 8'h01, "wake");
			@(posedge core_clk);
			pulse <= 1'b0;
			tmr <= 1'b0;
			ww(1'b0);
			slp <= 1'b0;
			rd(8'ha1, 8'h04, 8'h24);
			rd(8'haf, k ? 8'h08 : 8'h00, 8'hff);
		end
		// Level-one reset clears the pulse flag left by the last wake
		lvl <= 1'b1;
		@(posedge core_clk);
		lvl <= 1'b0;
		rd(8'haf, 8'h00, 8'hff);
		// Supply recovery is another level: it clears the level-one flag
		rcv <= 1'b1;
		@(posedge core_clk);
		rcv <= 1'b0;
		rd(8'ha1, 8'h00, 8'h2c);
		lvl <= 1'b1;
		@(posedge core_clk);
		lvl <= 1'b0;
		rd(8'ha1, 8'h20, 8'hff);
		low <= 1'b1;
		rd(8'ha1, 8'h02, 8'h03);
		chk(8'h01, {7'h00, pdi}, 8'h01, "pdi");
		pdi_en <= 1'b0;
		@(posedge core_clk);
		chk(8'h00, {7'h00, pdi}, 8'h01, "pdi");
		pdi_en <= 1'b1;
		low <= 1'b0;
		high <= 1'b1;
		rd(8'ha1, 8'h01, 8'h03);
		chk(8'h00, {7'h00, pdi}, 8'h01, "pdi");
		end_of_test;
	end
endmodule

// File: verilog/wake_pin_detect.v
// Edge detector with level qualification for one wakeup pin
`timescale 1ns/1ps
`include "wake_status_regs.vh"
module wake_pin_detect #(
	parameter HOLD = `PIN_HOLD_CYCLES
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Pin and configuration
	input wire pin_i,
	input wire [1:0] edge_sel_i,
	input wire enable_i,
	// Result
	output wire wake_o
);
	reg stable_r;
	reg prev_r;
	reg [3:0] hold_r;
	reg edge_r;
	wire rise;
	wire fall;
	// Count cycles the raw level differs from the accepted level
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stable_r <= 1'b1;
			hold_r <= 4'h0;
		end else if (pin_i == stable_r) begin
			hold_r <= 4'h0;
		end else if (hold_r == HOLD - 1) begin
			// Level held long enough: accept it
			stable_r <= pin_i;
			hold_r <= 4'h0;
		end else begin
			hold_r <= hold_r + 4'h1;
		end
	end
	// Previous accepted level for edge detection
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= stable_r;
		end
	end
	assign rise = stable_r & ~prev_r;
	assign fall = ~stable_r & prev_r;
	always @* begin
		case (edge_sel_i)
			`EDGE_RISE: edge_r = rise;
			`EDGE_ANY: edge_r = rise | fall;
			default: edge_r = fall;
		endcase
	end
	assign wake_o = enable_i & edge_r;
endmodule

// File: verilog/wake_status_regs.vh
// Register offsets, field positions and reset values of the wakeup status block
`ifndef WAKE_STATUS_REGS_VH
`define WAKE_STATUS_REGS_VH
`define SYSTEM_STATE_ADDR 8'ha1
`define WAKE_SOURCE_FLAGS_ADDR 8'haf
`define WAKE_EDGE_SELECT_ADDR 8'hc7
`define SS_LEVEL_ONE_BIT 5
`define SS_PIN_WAKE_BIT 3
`define SS_TIMER_PULSE_BIT 2
`define SS_SUPPLY_LOSS_BIT 1
`define SS_SUPPLY_PRESENT_BIT 0
`define WF_PULSE_BIT 3
`define WF_PIN_FOUR_BIT 2
`define WF_PIN_THREE_BIT 1
`define WF_PIN_ONE_BIT 0
`define ES_PIN_FOUR_LSB 6
`define ES_PIN_THREE_LSB 4
`define ES_PIN_ONE_LSB 2
`define ES_PIN_TWO_LSB 0
`define EDGE_FALL_A 2'h0
`define EDGE_RISE 2'h1
`define EDGE_ANY 2'h2
`define EDGE_SELECT_RESET 8'h00
`define FLAGS_RESET 8'h00
`define PIN_HOLD_CYCLES 5
`endif

// File: verilog/wakeup_source_status.v
// Wakeup and reset cause status registers with edge select control
// Operation
// - Level-one reset sets system state bit 5.
// - Any other level reset or wakeup clears bit 5.
// - Pin wakeup from sleep sets system state bit 3.
// - Timer or pulse sleep exit sets system state bit 2.
// - Pulse exit also sets flag bit 3; timer exit clears it.
// - Bit 1 reads one below 1.0 V; drives power-down interrupt if enabled.
// - Bit 0 reads one above 1.1 V, zero below 1.0 V.
// - Pin wakeup sets only the waking pin's flag bit; pin two has none.
// - Level-one reset clears the whole wakeup flag register.
// - Edge codes: 00/11 falling, 01 rising, 10 either.
// - Edge fields: pin four 7:6, three 5:4, one 3:2, two 1:0.
// - Pins three and four wake only with port-zero enable set.
`timescale 1ns/1ps
`include "wake_status_regs.vh"
module wakeup_source_status #(
	parameter HOLD = `PIN_HOLD_CYCLES
) (
	// Clock and reset
	input wire core_clk_i,
	input wire reset_n_i,
	// Reset and wakeup event sources
	input wire level_one_reset_i,
	input wire sleeping_i,
	input wire timer_wake_i,
	input wire energy_pulse_output_i,
	input wire pulse_wake_enable_i,
	input wire supply_recover_i,
	input wire line_supply_low_i,
	input wire line_supply_high_i,
	input wire port_zero_wake_enable_i,
	input wire power_down_int_enable_i,
	// Wakeup pins
	input wire wake_pin_one_i,
	input wire wake_pin_two_i,
	input wire wake_pin_three_i,
	input wire wake_pin_four_i,
	// Special function register port
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	// Results
	output wire wake_o,
	output wire power_down_int_o
);
	reg rst_meta_r;
	reg rst_sync_r;
	reg [7:0] wake_edge_select_reg_r;
	reg [7:0] wake_source_flag_reg_r;
	reg level_one_r;
	reg pin_wake_r;
	reg timer_pulse_r;
	reg supply_loss_flag_r;
	reg supply_present_flag_r;
	wire [3:0] pin_hit;
	wire pin_wake;
	wire pulse_wake;
	wire timer_wake;
	wire other_event;
	wire edge_select_write;
	wire [1:0] pin_one_edge_sel;
	wire [1:0] pin_two_edge_sel;
	wire [1:0] pin_three_edge_sel;
	wire [1:0] pin_four_edge_sel;
	reg [7:0] wake_source_flag_nxt;
	reg [7:0] system_state;
	// field slices of the edge select register
	assign pin_four_edge_sel =
		wake_edge_select_reg_r[`ES_PIN_FOUR_LSB+1:`ES_PIN_FOUR_LSB];
	assign pin_three_edge_sel =
		wake_edge_select_reg_r[`ES_PIN_THREE_LSB+1:`ES_PIN_THREE_LSB];
	assign pin_one_edge_sel =
		wake_edge_select_reg_r[`ES_PIN_ONE_LSB+1:`ES_PIN_ONE_LSB];
	assign pin_two_edge_sel =
		wake_edge_select_reg_r[`ES_PIN_TWO_LSB+1:`ES_PIN_TWO_LSB];
	// Reset release through two flip-flops, so that the release
	// never reaches the status flops close to a clock edge
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wake_pin_detect #(.HOLD(HOLD)) u_pin_one (
		.clk_i(core_clk_i),
		.rst_n_i(rst_sync_r),
		.pin_i(wake_pin_one_i),
		.edge_sel_i(pin_one_edge_sel),
		.enable_i(sleeping_i),
		.wake_o(pin_hit[0])
	);
	wake_pin_detect #(.HOLD(HOLD)) u_pin_two (
		.clk_i(core_clk_i),
		.rst_n_i(rst_sync_r),
		.pin_i(wake_pin_two_i),
		.edge_sel_i(pin_two_edge_sel),
		.enable_i(sleeping_i),
		.wake_o(pin_hit[1])
	);
	// port-zero enable gates pins three and four
	wake_pin_detect #(.HOLD(HOLD)) u_pin_three (
		.clk_i(core_clk_i),
		.rst_n_i(rst_sync_r),
		.pin_i(wake_pin_three_i),
		.edge_sel_i(pin_three_edge_sel),
		.enable_i(sleeping_i & port_zero_wake_enable_i),
		.wake_o(pin_hit[2])
	);
	wake_pin_detect #(.HOLD(HOLD)) u_pin_four (
		.clk_i(core_clk_i),
		.rst_n_i(rst_sync_r),
		.pin_i(wake_pin_four_i),
		.edge_sel_i(pin_four_edge_sel),
		.enable_i(sleeping_i & port_zero_wake_enable_i),
		.wake_o(pin_hit[3])
	);
	// Event qualification; pins win over timer and pulse in one cycle
	// A pin edge seen while awake is dropped, not kept for the next sleep
	assign pin_wake = |pin_hit;
	assign pulse_wake = sleeping_i & ~pin_wake & energy_pulse_output_i &
		pulse_wake_enable_i;
	assign timer_wake = sleeping_i & ~pin_wake & ~pulse_wake & timer_wake_i;
	assign other_event = pin_wake | pulse_wake | timer_wake |
		supply_recover_i;
	assign wake_o = pin_wake | pulse_wake | timer_wake;
	// Only the edge select register takes writes; the two status
	// registers are read only, so writes to them fall away here
	assign edge_select_write = sfr_wr_i &&
		(sfr_addr_i == `WAKE_EDGE_SELECT_ADDR);
	// Edge select register, software writable
	always @(posedge core_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			wake_edge_select_reg_r <= `EDGE_SELECT_RESET;
		end else if (edge_select_write) begin
			wake_edge_select_reg_r <= sfr_wdata_i;
		end
	end
	// Cause word of a wakeup; pin two owns no flag bit, so software
	// tells it apart only by the pin flag in the system state
	always @* begin
		wake_source_flag_nxt = `FLAGS_RESET;
		wake_source_flag_nxt[`WF_PULSE_BIT] = pulse_wake;
		wake_source_flag_nxt[`WF_PIN_FOUR_BIT] = pin_hit[3];
		wake_source_flag_nxt[`WF_PIN_THREE_BIT] = pin_hit[2];
		wake_source_flag_nxt[`WF_PIN_ONE_BIT] = pin_hit[0];
	end
	// Cause flags; level-one reset has priority over any wakeup
	always @(posedge core_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			level_one_r <= 1'b1;
			pin_wake_r <= 1'b0;
			timer_pulse_r <= 1'b0;
			wake_source_flag_reg_r <= `FLAGS_RESET;
		end else if (level_one_reset_i) begin
			level_one_r <= 1'b1;
			pin_wake_r <= 1'b0;
			timer_pulse_r <= 1'b0;
			wake_source_flag_reg_r <= `FLAGS_RESET;
		end else if (other_event) begin
			level_one_r <= 1'b0;
			pin_wake_r <= pin_wake;
			timer_pulse_r <= pulse_wake | timer_wake;
			// Cause word of this event
			wake_source_flag_reg_r <= wake_source_flag_nxt;
		end
	end
	// Supply comparator flags; between thresholds the old value holds
	always @(posedge core_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			supply_loss_flag_r <= 1'b0;
			supply_present_flag_r <= 1'b0;
		end else begin
			if (line_supply_low_i) begin
				supply_loss_flag_r <= 1'b1;
				supply_present_flag_r <= 1'b0;
			end else if (line_supply_high_i) begin
				supply_loss_flag_r <= 1'b0;
				supply_present_flag_r <= 1'b1;
			end
		end
	end
	assign power_down_int_o = power_down_int_enable_i & supply_loss_flag_r;
	// Status word from the field positions; reserved bits read zero
	always @* begin
		system_state = 8'h00;
		system_state[`SS_LEVEL_ONE_BIT] = level_one_r;
		system_state[`SS_PIN_WAKE_BIT] = pin_wake_r;
		system_state[`SS_TIMER_PULSE_BIT] = timer_pulse_r;
		system_state[`SS_SUPPLY_LOSS_BIT] = supply_loss_flag_r;
		system_state[`SS_SUPPLY_PRESENT_BIT] = supply_present_flag_r;
	end
	// Registered read data; unmapped addresses read zero
	always @(posedge core_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			case (sfr_addr_i)
				`SYSTEM_STATE_ADDR: sfr_rdata_o <= system_state;
				`WAKE_SOURCE_FLAGS_ADDR: sfr_rdata_o <= wake_source_flag_reg_r;
				`WAKE_EDGE_SELECT_ADDR: sfr_rdata_o <= wake_edge_select_reg_r;
				default: sfr_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule
